// file: hw/sppc_regs.svh
`ifndef SPPC_REGS_SVH
`define SPPC_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SPPC_CTRL_ADDR      4'h0
`define SPPC_STAT_ADDR      4'h4
`define SPPC_CTRL_LOOP      0
`define SPPC_CTRL_LOCKN     1
`define SPPC_CTRL_ENABLE    2
`define SPPC_CTRL_RESET     3'h6
`define SPPC_RESP_OKAY      2'h0
`define SPPC_RESP_SLVERR    2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define SPPC_CLK_PERIOD_NS  8
`define SPPC_POR_TIME_NS    8192
`define SPPC_POR_CYCLES     (`SPPC_POR_TIME_NS / `SPPC_CLK_PERIOD_NS)
`define SPPC_SER_RATIO      20

// ----------------------------------------
// serial symbol layout and codes
// ----------------------------------------
`define SPPC_KIND_MSB       19
`define SPPC_KIND_LSB       16
`define SPPC_KIND_IDLE      4'h1
`define SPPC_KIND_CARR      4'h2
`define SPPC_KIND_DATA      4'h4
`define SPPC_KIND_EPROP     4'h8
`define SPPC_IDLE_WORD      16'hc5bc
`define SPPC_CARR_WORD      16'hf7f7
`define SPPC_EPROP_WORD     16'hfefe
`define SPPC_LOS_WORD       16'hffff

// ----------------------------------------
// synchronisation counts
// ----------------------------------------
`define SPPC_ACQ_COUNT      3'h3
`define SPPC_GOOD_COUNT     3'h4
`define SPPC_BAD_COUNT      2'h3

`endif

// file: hw/sppc_pkg.sv
package sppc_pkg;

  typedef enum logic [1:0] {SPPC_ACQ, SPPC_SYNC, SPPC_CHECK} sppc_sync_t;

  typedef enum logic [1:0] {SPPC_PH_LOAD, SPPC_PH_RISE,
                            SPPC_PH_FALL} sppc_rxph_t;

  typedef enum logic [2:0] {SPPC_K_IDLE, SPPC_K_CARR, SPPC_K_DATA,
                            SPPC_K_EPROP, SPPC_K_BAD} sppc_kind_t;

endpackage

// file: hw/sppc_fifo.sv
module sppc_fifo
  import sppc_pkg::*;
#(
  parameter int W  = 18,
  parameter int D  = 8,
  parameter int LW = $clog2(D + 1)
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          flush,
  // fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  // occupancy
  output logic [LW-1:0]      level
);

  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam logic [PW-1:0] LAST = PW'(D - 1);
  localparam logic [LW-1:0] FULL = LW'(D);

  logic [W-1:0]  mem_r [D];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [LW-1:0] cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign level     = cnt_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_r <= FULL)
    else $error("fifo count above depth");

  a_fifo_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (push && !pop && !flush) |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("fifo count missed a push");

endmodule

// file: hw/sppc_top.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`include "sppc_regs.svh"

// How it works
// - transmit symbol carries twenty serial bit times per reference clock
// - serial outputs float in loopback, driven otherwise once enabled and out of power-on reset
// - serial outputs float during power-on reset
// - transmit word, enable and error captured every rising clock edge
// - lock-to-reference low makes receiver ignore data, transmit only
// - lock-to-reference low floats receive word, clock and status outputs
// - with lock high, transmitter sends idle until sync machine syncs
// - receive word stands stable at rising edge of receive clock
// - receive word outputs float during power-on reset
// - receive clock gives one pulse per twenty-bit word with status
// - receive clock held low during power-on reset
// - acquisition syncs on three consecutive idle or carrier codes, or at once on a data or error-propagation code
// - loopback feeds transmit symbols to receiver instead of serial input
// - enable low powers down; raising it runs power-on reset
module sppc_top
  import sppc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int POR_CYCLES = `SPPC_POR_CYCLES,
  parameter int LW         = $clog2(FIFO_DEPTH + 1)
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // transmit word from protocol device
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_enable,
  input  wire logic        tx_error_code,
  output logic             tx_ready,
  // serial transmit pair
  output logic [19:0]      serial_out_pos,
  output logic [19:0]      serial_out_neg,
  output logic             serial_out_oe,
  // serial receive pair
  input  wire logic [19:0] serial_in_pos,
  input  wire logic [19:0] serial_in_neg,
  input  wire logic        serial_in_valid,
  input  wire logic        serial_in_signal_ok,
  output logic             serial_in_ready,
  // receive word to protocol device
  output logic [15:0]      rx_data,
  output logic             rx_data_oe,
  output logic             rx_clk_out,
  output logic             rx_clk_oe,
  output logic             rx_error_flag,
  output logic             rx_error_oe,
  output logic             rx_valid_or_signal_loss,
  output logic             rx_valid_oe
);

  localparam logic [15:0]   POR_LOAD = 16'(POR_CYCLES);
  localparam logic [LW-1:0] LVL_HI   = LW'(FIFO_DEPTH - 3);

  function automatic sppc_kind_t kind_of(input logic [19:0] p,
                                         input logic [19:0] n);
    sppc_kind_t k;
    k = SPPC_K_BAD;
    if (p == ~n) begin
      case (p[`SPPC_KIND_MSB:`SPPC_KIND_LSB])
        `SPPC_KIND_IDLE:  k = SPPC_K_IDLE;
        `SPPC_KIND_CARR:  k = SPPC_K_CARR;
        `SPPC_KIND_DATA:  k = SPPC_K_DATA;
        `SPPC_KIND_EPROP: k = SPPC_K_EPROP;
        default:          k = SPPC_K_BAD;
      endcase
    end
    return k;
  endfunction

  logic [2:0]    ctrl_r;
  logic          aw_got_r, w_got_r;
  logic [3:0]    awaddr_r;
  logic [31:0]   wdata_r;
  logic          wstrb0_r;
  logic [15:0]   por_cnt_r;
  logic          por_r;
  logic [15:0]   cap_data_r;
  logic          cap_en_r, cap_er_r;
  sppc_sync_t    sync_r;
  logic [2:0]    good_r;
  logic [1:0]    bad_r;
  sppc_rxph_t    ph_r;
  logic          loop, lock_hi, pd, rx_run, tx_go, push, pop;
  logic [19:0]   src_pos, src_neg;
  logic          src_valid, fifo_in_ready, fifo_out_valid;
  sppc_kind_t    kind;
  logic [17:0]   fifo_in_data, fifo_out_data;
  logic [LW-1:0] level;
  logic [31:0]   stat_w;

  assign loop    = ctrl_r[`SPPC_CTRL_LOOP];
  assign lock_hi = ctrl_r[`SPPC_CTRL_LOCKN];
  assign pd      = !ctrl_r[`SPPC_CTRL_ENABLE];
  assign rx_run  = !pd && !por_r && lock_hi;
  assign tx_go   = !lock_hi || (sync_r != SPPC_ACQ);

  // ----------------------------------------
  // axi4-lite write path and control register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r        <= `SPPC_CTRL_RESET;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0;
      wstrb0_r      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb0_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == `SPPC_CTRL_ADDR) begin
          s_axi_bresp <= `SPPC_RESP_OKAY;
          if (wstrb0_r) begin
            ctrl_r <= wdata_r[2:0];
          end
        end else if (awaddr_r == `SPPC_STAT_ADDR) begin
          s_axi_bresp <= `SPPC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SPPC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  assign stat_w = {{(24 - LW){1'b0}}, level, 4'h0, tx_go,
                   sync_r == SPPC_CHECK, sync_r != SPPC_ACQ, por_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `SPPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `SPPC_RESP_OKAY;
      case (s_axi_araddr)
        `SPPC_CTRL_ADDR: s_axi_rdata <= {29'h0, ctrl_r};
        `SPPC_STAT_ADDR: s_axi_rdata <= stat_w;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `SPPC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // power-down and power-on reset
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_r <= POR_LOAD;
      por_r     <= 1'b1;
    end else begin
      if (pd) begin
        por_cnt_r <= POR_LOAD;
      end else if (por_cnt_r != 16'h0) begin
        por_cnt_r <= por_cnt_r - 16'h1;
      end
      por_r <= pd || (por_cnt_r != 16'h0);
    end
  end

  // ----------------------------------------
  // transmit capture and serial output
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_data_r <= 16'h0;
      cap_en_r   <= 1'b0;
      cap_er_r   <= 1'b0;
    end else begin
      cap_data_r <= tx_data;
      cap_en_r   <= tx_enable;
      cap_er_r   <= tx_error_code;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_pos <= 20'h0;
      serial_out_neg <= 20'hfffff;
      serial_out_oe  <= 1'b0;
    end else begin
      serial_out_oe <= !por_r && !pd && !loop;
      if (!tx_go || (!cap_en_r && !cap_er_r)) begin
        serial_out_pos <= {`SPPC_KIND_IDLE, `SPPC_IDLE_WORD};
        serial_out_neg <= ~{`SPPC_KIND_IDLE, `SPPC_IDLE_WORD};
      end else if (!cap_en_r) begin
        serial_out_pos <= {`SPPC_KIND_CARR, `SPPC_CARR_WORD};
        serial_out_neg <= ~{`SPPC_KIND_CARR, `SPPC_CARR_WORD};
      end else if (cap_er_r) begin
        serial_out_pos <= {`SPPC_KIND_EPROP, `SPPC_EPROP_WORD};
        serial_out_neg <= ~{`SPPC_KIND_EPROP, `SPPC_EPROP_WORD};
      end else begin
        serial_out_pos <= {`SPPC_KIND_DATA, cap_data_r};
        serial_out_neg <= ~{`SPPC_KIND_DATA, cap_data_r};
      end
    end
  end

  // ----------------------------------------
  // receive source, decode and buffer
  // ----------------------------------------
  assign src_pos   = loop ? serial_out_pos : serial_in_pos;
  assign src_neg   = loop ? serial_out_neg : serial_in_neg;
  assign src_valid = loop || (serial_in_valid && serial_in_ready);
  assign kind      = (!loop && !serial_in_signal_ok) ? SPPC_K_BAD
                                                      : kind_of(src_pos,
                                                                src_neg);
  assign push      = rx_run && src_valid && fifo_in_ready;

  always_comb begin
    fifo_in_data = {2'b11, src_pos[15:0]};
    if (!loop && !serial_in_signal_ok) begin
      fifo_in_data = {2'b11, `SPPC_LOS_WORD};
    end else begin
      case (kind)
        SPPC_K_IDLE:  fifo_in_data = {2'b00, src_pos[15:0]};
        SPPC_K_CARR:  fifo_in_data = {2'b01, src_pos[15:0]};
        SPPC_K_DATA:  fifo_in_data = {2'b10, src_pos[15:0]};
        SPPC_K_EPROP: fifo_in_data = {2'b11, `SPPC_EPROP_WORD};
        default:      fifo_in_data = {2'b11, src_pos[15:0]};
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_in_ready <= 1'b0;
      tx_ready        <= 1'b1;
    end else begin
      serial_in_ready <= rx_run && !loop && (level <= LVL_HI);
      tx_ready        <= !loop || (rx_run && (level <= LVL_HI));
    end
  end

  sppc_fifo #(
    .W  (18),
    .D  (FIFO_DEPTH),
    .LW (LW)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (!rx_run),
    .in_valid  (rx_run && src_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .level     (level)
  );

  // ----------------------------------------
  // synchronisation state machine
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      sync_r <= SPPC_ACQ;
      good_r <= 3'h0;
      bad_r  <= 2'h0;
    end else if (push) begin
      case (sync_r)
        SPPC_ACQ: begin
          if (kind == SPPC_K_IDLE || kind == SPPC_K_CARR) begin
            if (good_r == `SPPC_ACQ_COUNT - 3'h1) begin
              sync_r <= SPPC_SYNC;
              good_r <= 3'h0;
            end else begin
              good_r <= good_r + 3'h1;
            end
          end else if (kind == SPPC_K_BAD) begin
            good_r <= 3'h0;
          end else begin
            sync_r <= SPPC_SYNC;
            good_r <= 3'h0;
          end
        end
        SPPC_SYNC: begin
          if (kind == SPPC_K_BAD) begin
            sync_r <= SPPC_CHECK;
            good_r <= 3'h0;
            bad_r  <= 2'h1;
          end
        end
        SPPC_CHECK: begin
          if (kind == SPPC_K_BAD) begin
            good_r <= 3'h0;
            if (bad_r == `SPPC_BAD_COUNT - 2'h1) begin
              sync_r <= SPPC_ACQ;
              bad_r  <= 2'h0;
            end else begin
              bad_r <= bad_r + 2'h1;
            end
          end else if (good_r == `SPPC_GOOD_COUNT - 3'h1) begin
            sync_r <= SPPC_SYNC;
            good_r <= 3'h0;
            bad_r  <= 2'h0;
          end else begin
            good_r <= good_r + 3'h1;
          end
        end
        default: sync_r <= SPPC_ACQ;
      endcase
    end
  end

  // ----------------------------------------
  // receive word presentation and pin drive
  // ----------------------------------------
  assign pop = rx_run && (ph_r == SPPC_PH_LOAD) && fifo_out_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      ph_r       <= SPPC_PH_LOAD;
      rx_clk_out <= 1'b0;
    end else begin
      case (ph_r)
        SPPC_PH_LOAD: if (pop) ph_r <= SPPC_PH_RISE;
        SPPC_PH_RISE: begin
          rx_clk_out <= 1'b1;
          ph_r       <= SPPC_PH_FALL;
        end
        SPPC_PH_FALL: begin
          rx_clk_out <= 1'b0;
          ph_r       <= SPPC_PH_LOAD;
        end
        default: ph_r <= SPPC_PH_LOAD;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data                 <= 16'h0;
      rx_error_flag           <= 1'b0;
      rx_valid_or_signal_loss <= 1'b0;
    end else if (pd) begin
      rx_valid_or_signal_loss <= serial_in_signal_ok;
    end else if (pop) begin
      rx_data                 <= fifo_out_data[15:0];
      rx_error_flag           <= fifo_out_data[16];
      rx_valid_or_signal_loss <= fifo_out_data[17];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_oe  <= 1'b0;
      rx_error_oe <= 1'b0;
      rx_valid_oe <= 1'b0;
      rx_clk_oe   <= 1'b0;
    end else begin
      rx_data_oe  <= rx_run;
      rx_error_oe <= rx_run;
      rx_valid_oe <= lock_hi && (pd || !por_r);
      rx_clk_oe   <= lock_hi;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_clk_pulse;
    !rx_clk_out ##1 rx_clk_out ##1 !rx_clk_out;
  endsequence

  a_serial_diff: assert property (serial_out_oe |->
    serial_out_neg == ~serial_out_pos)
    else $error("serial pair not complementary");
  a_loop_float: assert property (loop |=> !serial_out_oe)
    else $error("serial pair driven in loopback");
  a_serial_drive: assert property ((!loop && !por_r && !pd)
    |=> serial_out_oe)
    else $error("serial pair not driven");
  a_por_serial: assert property (por_r |=> !serial_out_oe)
    else $error("serial pair driven in reset");
  a_tx_capture: assert property (##1 1'b1 |->
    cap_data_r == $past(tx_data) && cap_er_r == $past(tx_error_code))
    else $error("transmit word not captured");
  a_lock_nopush: assert property (!lock_hi |-> !push)
    else $error("receiver took data while locked to reference");
  a_lock_float: assert property (!lock_hi |=> !rx_data_oe &&
    !rx_clk_oe && !rx_error_oe && !rx_valid_oe)
    else $error("receive pins driven while locked to reference");
  a_tx_hold_idle: assert property ((lock_hi && sync_r == SPPC_ACQ)
    |=> serial_out_pos[19:16] == `SPPC_KIND_IDLE)
    else $error("transmitter sent before sync");
  a_rx_setup: assert property ($rose(rx_clk_out) |->
    $stable(rx_data) && $stable(rx_error_flag))
    else $error("receive word moved at clock rise");
  a_por_rxfloat: assert property (por_r |=> !rx_data_oe)
    else $error("receive word driven in reset");
  a_rx_clk_pulse: assert property ((pop ##1 rx_run)
    |-> s_clk_pulse)
    else $error("receive clock pulse malformed");
  a_por_clk_low: assert property ((por_r && lock_hi) |=>
    rx_clk_oe && !rx_clk_out)
    else $error("receive clock not low in reset");
  a_acq_sync: assert property ((push && sync_r == SPPC_ACQ &&
    good_r == 3'h2 && (kind == SPPC_K_IDLE || kind == SPPC_K_CARR))
    |=> sync_r == SPPC_SYNC)
    else $error("acquisition missed third idle");
  a_loop_route: assert property ((loop && push) |->
    src_pos == serial_out_pos)
    else $error("loopback not routed");
  a_enable_por: assert property ($rose(ctrl_r[`SPPC_CTRL_ENABLE])
    |-> ##1 por_r)
    else $error("no reset after enable");
  a_por_release: assert property (($fell(por_r) && lock_hi)
    |=> rx_data_oe && rx_clk_oe && rx_valid_oe)
    else $error("receive pins not released");

endmodule

// file: tb/sppc_link_model.sv
module sppc_link_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // command from bench
  input  wire logic        go,
  input  wire logic [19:0] sym,
  // serial receive side of the design
  output logic [19:0]      serial_in_pos,
  output logic [19:0]      serial_in_neg,
  output logic             serial_in_valid,
  output logic             serial_in_signal_ok,
  input  wire logic        serial_in_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  assign serial_in_signal_ok = 1'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_in_valid <= 1'h0;
      serial_in_pos   <= 20'h0;
      serial_in_neg   <= 20'hfffff;
    end else if (serial_in_valid && serial_in_ready) begin
      serial_in_valid <= 1'h0;
      // released symbol must not linger on the line
      serial_in_pos   <= ~serial_in_pos;
      serial_in_neg   <= ~serial_in_neg;
    end else if (go && !serial_in_valid) begin
      serial_in_valid <= 1'h1;
      serial_in_pos   <= sym;
      serial_in_neg   <= ~sym;
    end
  end
endmodule

// file: tb/sppc_top_tb.sv
`include "sppc_regs.svh"
module sppc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk;
  logic aresetn = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [15:0] tx_data = 0;
  logic tx_enable = 0, tx_error_code = 0, link_go = 0;
  logic [19:0] link_sym = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_ready, serial_out_oe, serial_in_ready;
  logic serial_in_valid, serial_in_signal_ok, rx_data_oe, rx_clk_out;
  logic rx_clk_oe, rx_error_flag, rx_error_oe, rx_valid_oe;
  logic rx_valid_or_signal_loss;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [19:0] serial_out_pos, serial_out_neg, serial_in_pos, serial_in_neg;
  logic [15:0] rx_data;
  logic [19:0] tx_exp [4] = '{{`SPPC_KIND_IDLE, `SPPC_IDLE_WORD},
    {`SPPC_KIND_DATA, 16'h1001}, {`SPPC_KIND_CARR, `SPPC_CARR_WORD},
    {`SPPC_KIND_EPROP, `SPPC_EPROP_WORD}};
  int miscompares = 0;
  int checks = 0;

  sppc_top #(.POR_CYCLES(8)) u_sppc_top (.*);
  sppc_link_model u_sppc_link_model (.aclk, .aresetn, .go(link_go),
    .sym(link_sym), .serial_in_pos, .serial_in_neg, .serial_in_valid,
    .serial_in_signal_ok, .serial_in_ready);

  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic final_report;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic send(input logic [19:0] s);
    @(posedge aclk);
    link_sym <= s;
    link_go <= 1'h1;
    @(posedge aclk);
    link_go <= 1'h0;
    while (!(serial_in_valid && serial_in_ready)) @(posedge aclk);
  endtask

  task automatic rx_word;
    do @(posedge aclk); while (rx_clk_out !== 1'h1);
  endtask

  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    #200000;
    miscompares++;
    final_report;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk(serial_out_oe, 0);
    chk({rx_data_oe, rx_error_oe, rx_valid_oe, rx_clk_out}, 0);
    axr(`SPPC_CTRL_ADDR);
    chk({r, d}, {`SPPC_RESP_OKAY, 29'h0, `SPPC_CTRL_RESET});
    axr(4'h8);
    chk({r, d}, {`SPPC_RESP_SLVERR, 32'h0});
    axw(4'h8, 32'h0);
    chk(r, `SPPC_RESP_SLVERR);
    repeat (12) @(posedge aclk);
    chk({serial_out_oe, rx_data_oe, rx_clk_oe}, 3'h7);
    tx_enable <= 1'h1;
    repeat (3) @(posedge aclk);
    chk(serial_out_pos, tx_exp[0]);
    send(tx_exp[0]);
    send(tx_exp[0]);
    repeat (10) @(posedge aclk);
    axr(`SPPC_STAT_ADDR);
    chk(d[1], 0);
    send(tx_exp[2]);
    repeat (10) @(posedge aclk);
    axr(`SPPC_STAT_ADDR);
    chk(d[1], 1);
    send({`SPPC_KIND_DATA, 16'ha55a});
    rx_word();
    chk({rx_valid_or_signal_loss, rx_error_flag, rx_data}, 18'h2a55a);
    @(posedge aclk);
    chk(rx_clk_out, 0);
    for (int i = 0; i < 4; i++) begin
      tx_enable <= i[0];
      tx_error_code <= i[1];
      tx_data <= 16'h1000 + 16'(i);
      repeat (3) @(posedge aclk);
      chk(serial_out_pos, tx_exp[i]);
      chk(serial_out_neg, 20'(~tx_exp[i]));
    end
    tx_enable <= 1'h1;
    tx_error_code <= 1'h0;
    tx_data <= 16'h3c3c;
    axw(`SPPC_CTRL_ADDR, 32'h7);
    chk(r, `SPPC_RESP_OKAY);
    repeat (30) @(posedge aclk);
    chk(serial_out_oe, 0);
    chk({tx_ready, serial_in_ready}, 2'h0);
    rx_word();
    chk({rx_valid_or_signal_loss, rx_error_flag, rx_data}, 18'h23c3c);
    axw(`SPPC_CTRL_ADDR, 32'h4);
    repeat (3) @(posedge aclk);
    chk({rx_data_oe, rx_clk_oe, rx_error_oe, rx_valid_oe}, 0);
    chk({serial_out_oe, serial_out_pos}, {1'h1, 4'h4, 16'h3c3c});
    axw(`SPPC_CTRL_ADDR, 32'h2);
    repeat (2) @(posedge aclk);
    chk(serial_out_oe, 0);
    axw(`SPPC_CTRL_ADDR, 32'h6);
    chk({serial_out_oe, rx_data_oe}, 0);
    repeat (15) @(posedge aclk);
    chk({serial_out_oe, rx_data_oe}, 2'h3);
    final_report;
  end
endmodule
